// >>> core/snps_fifo.sv
`timescale 1ns/100ps
module snps_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wp_r;
  logic [PW:0] rp_r;
  logic full;
  logic empty;

  assign empty = (wp_r == rp_r);
  assign full = (wp_r[PW] != rp_r[PW]) && (wp_r[PW-1:0] == rp_r[PW-1:0]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem_r[rp_r[PW-1:0]];

  // storage write
  always_ff @(posedge i_core_clk) begin
    if (i_in_valid && !full) begin
      mem_r[wp_r[PW-1:0]] <= i_in_data;
    end
  end

  // pointers with wrap bit
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wp_r <= wp_r + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // snps_fifo

// >>> core/snps_pkg.sv
package snps_pkg;
  // ---------------------------------------------------------------
  // serial framing
  // ---------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int PAY_BITS = 24;
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] PAY_LAST = 5'h17;
  localparam int ADDR_W = 16;
  localparam int WORD_W = 14;
  localparam int ROW_WORDS = 32;
  localparam int IDX_W = 5;
  localparam int J_BIT = 1;
  localparam logic [7:0] PAD_BITS = 8'h00;

  // ---------------------------------------------------------------
  // command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_LOAD_ADDR = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h18;
  localparam logic [7:0] CMD_ROW_ERASE = 8'hF0;
  localparam logic [7:0] CMD_LOAD_DATA = 8'h00;
  localparam logic [7:0] CMD_LOAD_DATA_INC = 8'h02;
  localparam logic [7:0] CMD_READ = 8'hFC;
  localparam logic [7:0] CMD_READ_INC = 8'hFE;
  localparam logic [7:0] CMD_INC_ADDR = 8'hF8;
  localparam logic [7:0] CMD_SELF_WRITE = 8'hE0;
  localparam logic [7:0] CMD_HOST_WRITE = 8'hC0;
  localparam logic [7:0] CMD_END_WRITE = 8'h82;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam logic [15:0] UID_FIRST = 16'h8000;
  localparam logic [15:0] UID_ROW_LAST = 16'h8004;
  localparam logic [15:0] CFG_FIRST = 16'h8007;
  localparam logic [15:0] CFG_LAST = 16'h800B;
  localparam logic [15:0] BULK_UID_LAST = 16'h80FD;
  localparam logic [15:0] UF_ONLY_LAST = 16'h80FF;
  localparam logic [15:0] HIGH_FIRST = 16'hE800;
  localparam logic [15:0] HIGH_LAST = 16'hEFFF;

  // erase region bit positions
  localparam int REG_UF = 0;
  localparam int REG_CFG = 1;
  localparam int REG_UID = 2;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SELF_WRITE_US = 2800;
  localparam int CFG_WRITE_US = 5600;
  localparam int BULK_ERASE_US = 8400;
  localparam int ROW_ERASE_US = 2800;
  localparam int TMR_W = 22;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_BULK = 3'b001,
    OP_ROW = 3'b010,
    OP_WRITE = 3'b100
  } snps_op_t;

  typedef enum logic [1:0] {
    SER_CMD = 2'b01,
    SER_PAY = 2'b10
  } snps_ser_t;

  typedef enum logic [2:0] {
    NV_IDLE = 3'b001,
    NV_TIMED = 3'b010,
    NV_HOST = 3'b100
  } snps_nv_t;
endpackage

// >>> core/snps_sequencer.sv
`timescale 1ns/100ps
// Function
// - self-timed write E0 commits the latch row under an internal timer
// - host-timed write C0 keeps the write active until the end command
// - host makes every serial clock pulse; device only receives it
// - receiver samples the data line on falling serial clock edges
// - load address sets the pointer; the pointer selects the region
// - bulk erase regions are chosen from the pointer, not code protect
// - bulk erase is a no-op in the unused range or while busy
// - row erase erases the pointed row; ignored when program memory protected
// - pointer in user-ID range: row erase hits only user IDs
// - rows are 32 words of 14 bits; host waits the row erase time
// - load data writes the latch picked by the five low pointer bits
// - command bit 1 makes load data and read advance the pointer
// - data pin drives from first payload fall until the 24th fall
// - protected program memory reads return zero
// - increment adds exactly one to the pointer
// - a finished self-timed write sets every latch to ones
// - host-timed write to a configuration word has no effect
// - end command is a no-op unless a host-timed write is active
// - the write row comes from the upper pointer bits at command time
// - loading past 32 words overwrites earlier latch contents
// - program flash writes a row, configuration writes one word
// - commands are 8 bits; payload commands take 24 more clocks
// - payload is start, pads, data msb first, stop
// - msb first; data changes on rising and is taken on falling
// - command codes 80, 18, F0, 00/02, FC/FE, F8
module snps_sequencer #(
  parameter int SELF_WRITE_CYC = snps_pkg::SELF_WRITE_US * snps_pkg::CLK_MHZ,
  parameter int CFG_WRITE_CYC = snps_pkg::CFG_WRITE_US * snps_pkg::CLK_MHZ,
  parameter int BULK_ERASE_CYC = snps_pkg::BULK_ERASE_US * snps_pkg::CLK_MHZ,
  parameter int ROW_ERASE_CYC = snps_pkg::ROW_ERASE_US * snps_pkg::CLK_MHZ,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_prog_serial_clock,
  input wire logic i_prog_serial_data,
  output logic o_prog_serial_data,
  output logic o_prog_serial_data_oe,
  input wire logic i_code_protect_n,
  output logic [snps_pkg::ADDR_W-1:0] o_nvm_rd_addr,
  input wire logic [snps_pkg::WORD_W-1:0] i_nvm_rd_data,
  output logic o_nvm_op_valid,
  output snps_pkg::snps_op_t o_nvm_op,
  output logic [snps_pkg::ADDR_W-1:0] o_nvm_op_addr,
  output logic [2:0] o_nvm_regions,
  output logic o_nvm_single,
  output logic o_nvm_host_timed,
  output logic o_nvm_end,
  output logic o_nvm_busy,
  input wire logic [snps_pkg::IDX_W-1:0] i_nvm_latch_idx,
  output logic [snps_pkg::WORD_W-1:0] o_nvm_latch_data
);
  import snps_pkg::*;

  localparam int LW = IDX_W + WORD_W;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic sck_fall;
  logic sck_rise;
  logic sda_lvl;

  // the serial clock is only ever an input here
  snps_sync u_sck (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_prog_serial_clock),
    .o_level(),
    .o_fall(sck_fall),
    .o_rise(sck_rise)
  );

  snps_sync u_sda (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_pin(i_prog_serial_data),
    .o_level(sda_lvl),
    .o_fall(),
    .o_rise()
  );

  // ---------------------------------------------------------------
  // serial framing
  // ---------------------------------------------------------------
  snps_ser_t ser_st_r;
  logic [4:0] bit_cnt_r;
  logic [PAY_BITS-1:0] sh_in_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_byte;
  logic [PAY_BITS-1:0] payload;
  logic cmd_done;
  logic pay_done;
  logic has_pay;

  // shift in msb first on each falling edge
  assign cmd_byte = {sh_in_r[CMD_BITS-2:0], sda_lvl};
  assign payload = {sh_in_r[PAY_BITS-2:0], sda_lvl};
  assign cmd_done = sck_fall && (ser_st_r == SER_CMD) && (bit_cnt_r == CMD_LAST);
  assign pay_done = sck_fall && (ser_st_r == SER_PAY) && (bit_cnt_r == PAY_LAST);
  assign has_pay = (cmd_byte == CMD_LOAD_ADDR) || (cmd_byte == CMD_LOAD_DATA) ||
                   (cmd_byte == CMD_LOAD_DATA_INC) || (cmd_byte == CMD_READ) ||
                   (cmd_byte == CMD_READ_INC);

  // command byte then optional 24 clock payload
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ser_st_r <= SER_CMD;
      bit_cnt_r <= '0;
      sh_in_r <= '0;
      cmd_r <= '0;
    end else if (sck_fall) begin
      sh_in_r <= payload;
      bit_cnt_r <= bit_cnt_r + 1'b1;
      case (ser_st_r)
        SER_CMD: begin
          if (cmd_done) begin
            bit_cnt_r <= '0;
            cmd_r <= cmd_byte;
            if (has_pay) begin
              ser_st_r <= SER_PAY;
            end
          end
        end
        SER_PAY: begin
          if (pay_done) begin
            bit_cnt_r <= '0;
            ser_st_r <= SER_CMD;
          end
        end
        default: begin
          ser_st_r <= SER_CMD;
        end
      endcase
    end
  end

  logic is_load;
  logic is_read;
  assign is_load = (cmd_r == CMD_LOAD_DATA) || (cmd_r == CMD_LOAD_DATA_INC);
  assign is_read = (cmd_r == CMD_READ) || (cmd_r == CMD_READ_INC);

  // ---------------------------------------------------------------
  // address pointer
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] ptr_r;

  // load, post-access advance and increment only, never decrement
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r <= '0;
    end else if (pay_done) begin
      if (cmd_r == CMD_LOAD_ADDR) begin
        ptr_r <= payload[ADDR_W:1];
      end else if ((is_load || is_read) && cmd_r[J_BIT]) begin
        ptr_r <= ptr_r + 1'b1;
      end
    end else if (cmd_done && (cmd_byte == CMD_INC_ADDR)) begin
      ptr_r <= ptr_r + 1'b1;
    end
  end

  assign o_nvm_rd_addr = ptr_r;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [PAY_BITS-1:0] sh_out_r;
  logic oe_r;
  logic prot_pm;
  logic [WORD_W-1:0] rd_word;

  assign prot_pm = !i_code_protect_n && (ptr_r < UID_FIRST);
  assign rd_word = prot_pm ? '0 : i_nvm_rd_data;

  // frame: start, pads, data, stop; shifted on rising edges
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sh_out_r <= '0;
    end else if (cmd_done && ((cmd_byte == CMD_READ) || (cmd_byte == CMD_READ_INC))) begin
      sh_out_r <= {1'b0, PAD_BITS, rd_word, 1'b0};
    end else if (sck_rise && oe_r) begin
      sh_out_r <= {sh_out_r[PAY_BITS-2:0], 1'b0};
    end
  end

  // drive from first payload fall to the 24th fall
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_r <= 1'b0;
    end else if (pay_done) begin
      oe_r <= 1'b0;
    end else if (sck_fall && (ser_st_r == SER_PAY) && is_read && (bit_cnt_r == '0)) begin
      oe_r <= 1'b1;
    end
  end

  assign o_prog_serial_data = sh_out_r[PAY_BITS-1];
  assign o_prog_serial_data_oe = oe_r;

  // ---------------------------------------------------------------
  // load buffering
  // ---------------------------------------------------------------
  logic pend_r;
  logic [LW-1:0] pend_word_r;
  logic fifo_in_rdy;
  logic fifo_out_vld;
  logic [LW-1:0] fifo_out;
  logic drain_rdy;
  snps_nv_t nv_st_r;

  // held word waits for room; a newer load replaces it
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_r <= 1'b0;
      pend_word_r <= '0;
    end else if (pay_done && is_load) begin
      pend_r <= 1'b1;
      pend_word_r <= {ptr_r[IDX_W-1:0], payload[WORD_W:1]};
    end else if (fifo_in_rdy) begin
      pend_r <= 1'b0;
    end
  end

  // the FIFO does not drain into the latches while a commit is running
  assign drain_rdy = (nv_st_r == NV_IDLE);

  snps_fifo #(
    .WIDTH(LW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_in_valid(pend_r),
    .o_in_ready(fifo_in_rdy),
    .i_in_data(pend_word_r),
    .o_out_valid(fifo_out_vld),
    .i_out_ready(drain_rdy),
    .o_out_data(fifo_out)
  );

  // ---------------------------------------------------------------
  // write latches
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] latch_r [ROW_WORDS];
  logic self_done;

  // one latch per row word; later loads overwrite
  for (genvar gi = 0; gi < ROW_WORDS; gi++) begin : g_latch
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        latch_r[gi] <= '1;
      end else if (self_done) begin
        latch_r[gi] <= '1;
      end else if (fifo_out_vld && drain_rdy &&
                   (fifo_out[LW-1:WORD_W] == IDX_W'(gi))) begin
        latch_r[gi] <= fifo_out[WORD_W-1:0];
      end
    end
  end

  // registered latch port for the array during a commit
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nvm_latch_data <= '1;
    end else begin
      o_nvm_latch_data <= latch_r[i_nvm_latch_idx];
    end
  end

  // ---------------------------------------------------------------
  // erase and write sequencing
  // ---------------------------------------------------------------
  logic busy;
  logic in_cfg;
  logic in_uid;
  logic [2:0] bulk_reg;
  logic start;
  snps_op_t start_op;
  logic [2:0] start_reg;
  logic [TMR_W-1:0] start_cyc;
  logic start_host;
  logic [TMR_W-1:0] tmr_r;
  logic timed_wr_r;

  assign busy = (nv_st_r != NV_IDLE);
  assign in_cfg = (ptr_r >= CFG_FIRST) && (ptr_r <= CFG_LAST);
  assign in_uid = (ptr_r >= UID_FIRST) && (ptr_r <= UID_ROW_LAST);

  // bulk regions by pointer only, protect not consulted
  always_comb begin
    bulk_reg = '0;
    if (ptr_r < UID_FIRST) begin
      bulk_reg[REG_UF] = 1'b1;
      bulk_reg[REG_CFG] = 1'b1;
    end else if (ptr_r <= BULK_UID_LAST) begin
      bulk_reg = '1;
    end else if (ptr_r <= UF_ONLY_LAST) begin
      bulk_reg[REG_UF] = 1'b1;
    end else if ((ptr_r >= HIGH_FIRST) && (ptr_r <= HIGH_LAST)) begin
      bulk_reg = '1;
    end
  end

  // decide what a finished command byte starts
  always_comb begin
    start = 1'b0;
    start_op = OP_WRITE;
    start_reg = '0;
    start_cyc = '0;
    start_host = 1'b0;
    if (cmd_done && !busy) begin
      case (cmd_byte)
        CMD_BULK: begin
          start = (bulk_reg != '0);
          start_op = OP_BULK;
          start_reg = bulk_reg;
          start_cyc = TMR_W'(BULK_ERASE_CYC);
        end
        CMD_ROW_ERASE: begin
          start = in_uid || !prot_pm;
          start_op = OP_ROW;
          start_reg[REG_UID] = in_uid;
          start_reg[REG_UF] = (ptr_r < UID_FIRST);
          start_reg[REG_CFG] = !in_uid && (ptr_r >= UID_FIRST);
          start_cyc = TMR_W'(ROW_ERASE_CYC);
        end
        CMD_SELF_WRITE: begin
          start = 1'b1;
          start_cyc = in_cfg ? TMR_W'(CFG_WRITE_CYC) : TMR_W'(SELF_WRITE_CYC);
        end
        CMD_HOST_WRITE: begin
          start = !in_cfg;
          start_host = 1'b1;
        end
        default: begin
          start = 1'b0;
        end
      endcase
    end
  end

  // operation state: idle, timed by the counter, or held for the host
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nv_st_r <= NV_IDLE;
      tmr_r <= '0;
      timed_wr_r <= 1'b0;
    end else begin
      case (nv_st_r)
        NV_IDLE: begin
          if (start) begin
            nv_st_r <= start_host ? NV_HOST : NV_TIMED;
            tmr_r <= start_cyc;
            timed_wr_r <= (start_op == OP_WRITE);
          end
        end
        NV_TIMED: begin
          if (tmr_r == '0) begin
            nv_st_r <= NV_IDLE;
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        NV_HOST: begin
          if (cmd_done && (cmd_byte == CMD_END_WRITE)) begin
            nv_st_r <= NV_IDLE;
          end
        end
        default: begin
          nv_st_r <= NV_IDLE;
        end
      endcase
    end
  end

  assign self_done = (nv_st_r == NV_TIMED) && (tmr_r == '0) && timed_wr_r;
  assign o_nvm_busy = busy;

  // request to the array, row aligned unless a single config word
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nvm_op_valid <= 1'b0;
      o_nvm_op <= OP_WRITE;
      o_nvm_op_addr <= '0;
      o_nvm_regions <= '0;
      o_nvm_single <= 1'b0;
      o_nvm_host_timed <= 1'b0;
    end else begin
      o_nvm_op_valid <= start;
      if (start) begin
        o_nvm_op <= start_op;
        o_nvm_regions <= start_reg;
        o_nvm_host_timed <= start_host;
        o_nvm_single <= (start_op == OP_WRITE) && in_cfg;
        o_nvm_op_addr <= (start_op == OP_WRITE && in_cfg) ? ptr_r :
                         {ptr_r[ADDR_W-1:IDX_W], {IDX_W{1'b0}}};
      end
    end
  end

  // end pulse only while a host-timed write is running
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_nvm_end <= 1'b0;
    end else begin
      o_nvm_end <= cmd_done && (cmd_byte == CMD_END_WRITE) && (nv_st_r == NV_HOST);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  oe_on_a: assert property (
    (sck_fall && ser_st_r == SER_PAY && is_read && bit_cnt_r == '0) |=> oe_r
  ) else $error("data pin not driven after first read fall");

  oe_off_a: assert property (
    (pay_done && is_read) |=> !oe_r ##1 !oe_r
  ) else $error("data pin still driven after last fall");

  ptr_load_a: assert property (
    (pay_done && cmd_r == CMD_LOAD_ADDR) |=> ptr_r == $past(payload[ADDR_W:1])
  ) else $error("pointer not loaded from payload");

  ptr_inc_a: assert property (
    (cmd_done && cmd_byte == CMD_INC_ADDR) |=> ptr_r == $past(ptr_r) + 16'h0001
  ) else $error("increment did not add one");

  bulk_nop_a: assert property (
    (cmd_done && cmd_byte == CMD_BULK && (busy || bulk_reg == '0)) |=> !o_nvm_op_valid
  ) else $error("bulk erase started when it must not");

  row_prot_a: assert property (
    (o_nvm_op_valid && o_nvm_op == OP_ROW && o_nvm_regions[REG_UF]) |-> i_code_protect_n
  ) else $error("row erase of protected program memory");

  host_cfg_a: assert property (
    (cmd_done && cmd_byte == CMD_HOST_WRITE && in_cfg) |=> !o_nvm_op_valid
  ) else $error("host-timed write reached a config word");

  read_zero_a: assert property (
    (cmd_done && cmd_byte == CMD_READ && prot_pm) |=> sh_out_r[WORD_W:1] == '0
  ) else $error("protected read returned data");

  latch_ones_a: assert property (
    self_done |=> (latch_r[0] == '1) && (latch_r[ROW_WORDS-1] == '1)
  ) else $error("latches not set after self-timed write");

  end_nop_a: assert property (
    (cmd_done && cmd_byte == CMD_END_WRITE && nv_st_r != NV_HOST) |=> !o_nvm_end
  ) else $error("end command acted without host-timed write");

  host_hold_a: assert property (
    (nv_st_r == NV_HOST && !(cmd_done && cmd_byte == CMD_END_WRITE)) |=> nv_st_r == NV_HOST
  ) else $error("host-timed write ended without end command");

  cov_read_c: cover property (pay_done && is_read);
  cov_bulk_c: cover property (o_nvm_op_valid && o_nvm_op == OP_BULK);
  cov_self_c: cover property (self_done);
  cov_host_c: cover property (o_nvm_end);
endmodule // snps_sequencer

// >>> core/snps_sync.sv
`timescale 1ns/100ps
module snps_sync (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall,
  output logic o_rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // three stage chain; only stage two feeds stage three
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // filtered level moves only when stages two and three agree
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lvl_r <= 1'b0;
    end else if (s2_r == s3_r) begin
      lvl_r <= s3_r;
    end
  end

  assign o_level = lvl_r;
  assign o_fall = lvl_r & (s2_r == s3_r) & ~s3_r;
  assign o_rise = ~lvl_r & (s2_r == s3_r) & s3_r;
endmodule // snps_sync

// >>> dv/serial_nvm_program_sequencer_tb.sv
`timescale 1ns/100ps
module serial_nvm_program_sequencer_tb;
  import snps_pkg::*;
  logic clk, arst_n, cp_n, sclk, hdat, hdrv, sdat, oe, dline, last, busy, opv, endp, ht, sg;
  logic [15:0] ptr, a, oaddr;
  logic [13:0] rdd, d, lat;
  logic [4:0] idx;
  logic [2:0] regs, rg, op;
  int fail_count, cmp_count, nops, nend, n0, n1;
  logic [15:0] ba[5] = '{16'h1234, 16'h80FD, 16'h80FE, 16'h8100, 16'hE800};
  logic [2:0] br[5] = '{3'b011, 3'b111, 3'b001, 3'b000, 3'b111};
  // ----------------------------------------
  // wire, clock and parts
  // ----------------------------------------
  assign dline = oe ? sdat : (hdrv ? hdat : ~last);
  always @(dline) if (oe | hdrv) last = dline;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  snps_host_model h (.i_sdat(dline), .o_sclk(sclk), .o_sdat(hdat), .o_drv(hdrv));
  snps_sequencer #(.SELF_WRITE_CYC(20), .CFG_WRITE_CYC(20), .BULK_ERASE_CYC(20),
    .ROW_ERASE_CYC(20), .FIFO_DEPTH(4)) dut (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_prog_serial_clock(sclk), .i_prog_serial_data(dline), .o_prog_serial_data(sdat),
    .o_prog_serial_data_oe(oe), .i_code_protect_n(cp_n), .o_nvm_rd_addr(ptr),
    .i_nvm_rd_data(rdd), .o_nvm_op_valid(opv), .o_nvm_op(op), .o_nvm_op_addr(oaddr),
    .o_nvm_regions(regs), .o_nvm_single(sg), .o_nvm_host_timed(ht), .o_nvm_end(endp),
    .o_nvm_busy(busy), .i_nvm_latch_idx(idx), .o_nvm_latch_data(lat));
  // counts operation starts and end pulses
  always @(posedge clk) begin
    if (opv === 1'b1) begin
      nops++;
      rg <= regs;
    end
    if (endp === 1'b1) nend++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic latch_at(input logic [4:0] i);
    idx <= i;
    repeat (3) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    cp_n = 1'b1;
    rdd = '0;
    idx = '0;
    void'($urandom(32'he151_8b18));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      n0 = nops;
      h.xfer(CMD_LOAD_ADDR, ba[i], 1'b1, 1'b0);
      chk(ptr, ba[i]);
      h.xfer(CMD_BULK, '0, 1'b0, 1'b0);
      chk(16'(nops - n0), {15'h0000, |br[i]});
      if (br[i] != 3'b000) chk({13'h0000, rg}, {13'h0000, br[i]});
    end
    a = 16'($urandom) & 16'h7FEF;
    d = 14'($urandom);
    h.xfer(CMD_LOAD_ADDR, a, 1'b1, 1'b0);
    h.xfer(CMD_LOAD_DATA_INC, {2'b00, d}, 1'b1, 1'b0);
    h.xfer(CMD_LOAD_DATA, {2'b00, ~d}, 1'b1, 1'b0);
    h.xfer(CMD_LOAD_DATA, {2'b00, d ^ 14'h0F0F}, 1'b1, 1'b0);
    chk(ptr, a + 16'h0001);
    latch_at(a[4:0]);
    chk({2'b00, lat}, {2'b00, d});
    latch_at(a[4:0] + 5'h01);
    chk({2'b00, lat}, {2'b00, d ^ 14'h0F0F});
    h.xfer(CMD_INC_ADDR, '0, 1'b0, 1'b0);
    chk(ptr, a + 16'h0002);
    n0 = nend;
    h.xfer(CMD_END_WRITE, '0, 1'b0, 1'b0);
    chk(16'(nend - n0), 16'h0000);
    h.xfer(CMD_HOST_WRITE, '0, 1'b0, 1'b0);
    chk({14'h0000, ht, busy}, 16'h0003);
    n1 = nops;
    h.xfer(CMD_BULK, '0, 1'b0, 1'b0);
    chk(16'(nops - n1), 16'h0000);
    h.xfer(CMD_END_WRITE, '0, 1'b0, 1'b0);
    chk({15'h0000, busy}, 16'h0000);
    chk(16'(nend - n0), 16'h0001);
    h.xfer(CMD_SELF_WRITE, '0, 1'b0, 1'b0);
    chk(oaddr, (a + 16'h0002) & 16'hFFE0);
    chk({12'h000, op, sg}, {12'h000, OP_WRITE, 1'b0});
    latch_at(a[4:0]);
    chk({1'b0, busy, lat}, 16'h3FFF);
    @(posedge clk);
    rdd <= 14'($urandom);
    h.xfer(CMD_LOAD_ADDR, a, 1'b1, 1'b0);
    h.xfer(CMD_READ_INC, '0, 1'b1, 1'b1);
    chk({2'b00, h.rx[14:1]}, {2'b00, rdd});
    chk({oe, ptr[14:0]}, a + 16'h0001);
    @(posedge clk);
    cp_n <= 1'b0;
    h.xfer(CMD_READ, '0, 1'b1, 1'b1);
    chk({2'b00, h.rx[14:1]}, 16'h0000);
    chk(ptr, a + 16'h0001);
    n0 = nops;
    h.xfer(CMD_ROW_ERASE, '0, 1'b0, 1'b0);
    chk(16'(nops - n0), 16'h0000);
    h.xfer(CMD_LOAD_ADDR, 16'h8002, 1'b1, 1'b0);
    h.xfer(CMD_ROW_ERASE, '0, 1'b0, 1'b0);
    chk({13'(nops - n0), rg}, 16'h000C);
    chk({13'h0000, op}, {13'h0000, OP_ROW});
    h.xfer(CMD_LOAD_ADDR, 16'h8008, 1'b1, 1'b0);
    n1 = nops;
    h.xfer(CMD_HOST_WRITE, '0, 1'b0, 1'b0);
    chk({15'(nops - n1), busy}, 16'h0000);
    h.xfer(CMD_SELF_WRITE, '0, 1'b0, 1'b0);
    chk(oaddr, 16'h8008);
    chk({12'h000, op, sg}, {12'h000, OP_WRITE, 1'b1});
    tally_and_finish();
  end
endmodule // serial_nvm_program_sequencer_tb

// >>> dv/snps_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// programmer host model
// ----------------------------------------
module snps_host_model (
  input wire logic i_sdat,
  output logic o_sclk,
  output logic o_sdat,
  output logic o_drv
);
  logic [23:0] rx;
  // serial clock rests low outside frames
  initial begin
    o_sclk = 1'b0;
    o_sdat = 1'b0;
    o_drv = 1'b1;
    rx = '0;
  end
  // data moves on the rise, both sides take it on the fall
  task automatic bit1(input logic b, input logic rd);
    o_sclk = 1'b1;
    o_drv = ~rd;  // released only for a read payload
    o_sdat = b;
    #62.5;
    o_sclk = 1'b0;
    rx = {rx[22:0], i_sdat};  // caller keeps data bits only
    #62.5;
  endtask
  // byte msb first, then start, pads, value, stop; start, pads and stop driven low
  task automatic xfer(input logic [7:0] c, input logic [15:0] v, input logic pay,
                      input logic rd);
    logic [23:0] f;
    f = {7'h00, v, 1'b0};
    for (int i = 7; i >= 0; i--) bit1(c[i], 1'b0);
    #1000;
    if (pay) begin
      for (int i = 23; i >= 0; i--) bit1(f[i], rd);
    end
    o_drv = 1'b1;
    #1000;  // longer than every shortened operation time
  endtask
endmodule // snps_host_model
